//--- hdl/chpseq_params.svh
// Constants of the chipset power-up sequencer
`ifndef CHPSEQ_PARAMS_SVH
`define CHPSEQ_PARAMS_SVH

// Clock and timing figures
`define CHPSEQ_CLK_PERIOD_NS 20
`define CHPSEQ_TIMEOUT_NS    32000000
`define CHPSEQ_TIMEOUT_CYC   \
	((`CHPSEQ_TIMEOUT_NS + `CHPSEQ_CLK_PERIOD_NS - 1) / \
	`CHPSEQ_CLK_PERIOD_NS)
`define CHPSEQ_RSTDLY_NS     20000
`define CHPSEQ_RSTDLY_CYC    \
	((`CHPSEQ_RSTDLY_NS + `CHPSEQ_CLK_PERIOD_NS - 1) / \
	`CHPSEQ_CLK_PERIOD_NS)
`define CHPSEQ_TOG_PULSES    8
`define CHPSEQ_TOG_DIV       4
`define CHPSEQ_TRAIN_CYC     (`CHPSEQ_TOG_PULSES * `CHPSEQ_TOG_DIV)
`define CHPSEQ_CNT_W         21

// Register map
`define CHPSEQ_ADDR_W        16
`define CHPSEQ_STATUS2_ADDR  16'hE503
`define CHPSEQ_DONE_FLAG_BIT 15
`define CHPSEQ_STATUS2_RST   32'h00000000

`endif

//--- hdl/chpseq_pkg.sv
// Types of the chipset power-up sequencer
package chpseq_pkg;
	`include "chpseq_params.svh"

	typedef enum logic [4:0] {
		ST_OFF    = 5'h01,
		ST_WAIT   = 5'h02,
		ST_CLKRUN = 5'h04,
		ST_TRAIN  = 5'h08,
		ST_DONE   = 5'h10
	} chpseq_state_type;

	typedef struct packed {
		chpseq_state_type          state;
		logic [`CHPSEQ_CNT_W-1:0]  cnt;
		logic                      pu_m;
		logic                      pu_s;
		logic                      low_m;
		logic                      low_s;
		logic                      sat_clk;
		logic                      rst_en_n;
		logic [3:0]                tog;
		logic                      flag;
		logic                      irq_n;
		logic                      i2c_sel;
		logic                      dflt_load;
		logic                      active;
		logic [31:0]               rdata;
	} chpseq_top_type;

	typedef struct packed {
		logic [1:0] cnt;
	} chpseq_div_type;
endpackage

//--- hdl/chpseq_div.sv
// Quarter-rate phase divider for the satellite clock
`timescale 1ns/1ps
module chpseq_div (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	// Control
	input  wire logic       run_i,
	// Phase out
	output logic [1:0]      phase_o
);
	import chpseq_pkg::*;

	chpseq_div_type d_r;
	chpseq_div_type d_nxt;

	// Count phases only while the clock runs
	always_comb begin
		d_nxt = d_r;
		if (run_i) begin
			d_nxt.cnt = d_r.cnt + 2'h1;
		end else begin
			d_nxt.cnt = 2'h0;
		end
	end

	// State register
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			d_r <= '0;
		end else begin
			d_r <= d_nxt;
		end
	end

	assign phase_o = d_r.cnt;
endmodule

//--- hdl/chpseq_top.sv
// Chipset power-up sequencer: supply wait, timeout, satellite reset
//
// Behaviour
// R1: The device stays inactive until the supply monitor reports power-up.
// R2: After the threshold it stays inactive for a further 32 ms timeout.
// R3: After the timeout it drives a continuous quarter-rate satellite clock.
// R4: 20 us after the clock starts the reset enable goes low.
// R5: During reset all four toggles fall exactly eight times at quarter rate.
// R6: After the toggles the reset enable and all toggles return high.
// R7: Satellites run from the clock and take defaults after the pulse train.
// R8: Only the master supply monitor and timeout gate the sequence.
// R9: On completion interrupt line one goes low and the done flag is set.
// R10: The done flag reads zero during the sequence and one on completion.
// R11: Writing one to the flag clears it; the line stays low until then.
// R12: On completion the two-wire serial port is selected.
// R13: On completion all registers are loaded with defaults.
// R14: A supply drop puts the chipset inactive and stops all work.
// R15: After a drop the whole sequence restarts with the threshold wait.
`timescale 1ns/1ps
`include "chpseq_params.svh"
module chpseq_top #(
	parameter logic [`CHPSEQ_CNT_W-1:0] TIMEOUT_CYC =
		`CHPSEQ_CNT_W'(`CHPSEQ_TIMEOUT_CYC)
) (
	// Clock and reset
	input  wire logic                         mclk_i,
	input  wire logic                         nrst_i,
	// Supply monitor
	input  wire logic                         supply_ok_i,
	input  wire logic                         supply_low_i,
	// Register port
	input  wire logic                         reg_wr_i,
	input  wire logic                         reg_rd_i,
	input  wire logic [`CHPSEQ_ADDR_W-1:0]    reg_addr_i,
	input  wire logic [31:0]                  reg_wdata_i,
	output logic [31:0]                       reg_rdata_o,
	// Satellite link
	output logic                              satellite_clock_output_o,
	output logic                              satellite_reset_en_n_o,
	output logic                              channel_a_toggle_o,
	output logic                              channel_b_toggle_o,
	output logic                              channel_c_toggle_o,
	output logic                              neutral_toggle_o,
	// Host side
	output logic                              interrupt_line_one_n_o,
	output logic                              i2c_port_sel_o,
	output logic                              defaults_load_o,
	output logic                              chip_active_o
);
	import chpseq_pkg::*;

	localparam int CW = `CHPSEQ_CNT_W;
	localparam logic [CW-1:0] TIMEOUT_LAST = TIMEOUT_CYC - CW'(1);
	localparam logic [CW-1:0] RSTDLY_LAST = CW'(`CHPSEQ_RSTDLY_CYC - 1);
	localparam logic [CW-1:0] TRAIN_LAST = CW'(`CHPSEQ_TRAIN_CYC - 1);

	chpseq_top_type   s_r;
	chpseq_top_type   s_nxt;
	logic             sat_run;
	logic [1:0]       div_phase;
	logic [CW-1:0]    cnt_inc;
	logic             clr_wr;

	// Address decode of the flag register, shared by write and read
	function automatic logic is_flags_addr(
		input logic [`CHPSEQ_ADDR_W-1:0] a);
		return (a == `CHPSEQ_STATUS2_ADDR);
	endfunction

	// Satellite clock phase source
	chpseq_div u_div (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.run_i   (sat_run),
		.phase_o (div_phase)
	);

	// Clock runs from the end of the timeout onward
	assign sat_run = (s_r.state == ST_CLKRUN) || (s_r.state == ST_TRAIN) ||
		(s_r.state == ST_DONE); // R3
	assign cnt_inc = s_r.cnt + CW'(1);
	assign clr_wr = reg_wr_i && is_flags_addr(reg_addr_i) &&
		reg_wdata_i[`CHPSEQ_DONE_FLAG_BIT];

	// Sequencer next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.pu_m = supply_ok_i;
		s_nxt.pu_s = s_r.pu_m;
		s_nxt.low_m = supply_low_i;
		s_nxt.low_s = s_r.low_m;
		s_nxt.dflt_load = 1'b0;
		s_nxt.sat_clk = sat_run ? ~div_phase[1] : 1'b1; // R3
		// Host clears the done flag by writing one
		if (clr_wr) begin
			s_nxt.flag = 1'b0; // R11
		end
		unique case (s_r.state)
			ST_OFF: begin
				s_nxt.cnt = '0;
				if (s_r.pu_s && !s_r.low_s) begin
					s_nxt.state = ST_WAIT; // R1 R8
				end
			end
			ST_WAIT: begin
				if (s_r.cnt == TIMEOUT_LAST) begin
					s_nxt.state = ST_CLKRUN; // R2
					s_nxt.cnt = '0;
				end else begin
					s_nxt.cnt = cnt_inc;
				end
			end
			ST_CLKRUN: begin
				if (s_r.cnt == RSTDLY_LAST) begin
					s_nxt.state = ST_TRAIN; // R4
					s_nxt.cnt = '0;
					s_nxt.rst_en_n = 1'b0;
					s_nxt.tog = 4'h0;
				end else begin
					s_nxt.cnt = cnt_inc;
				end
			end
			ST_TRAIN: begin
				if (s_r.cnt == TRAIN_LAST) begin
					s_nxt.state = ST_DONE;
					s_nxt.cnt = '0;
					s_nxt.rst_en_n = 1'b1; // R6
					s_nxt.tog = 4'hF; // R6
					s_nxt.flag = 1'b1; // R9 R10
					s_nxt.i2c_sel = 1'b1; // R12
					s_nxt.dflt_load = 1'b1; // R13
					s_nxt.active = 1'b1;
				end else begin
					s_nxt.cnt = cnt_inc;
					s_nxt.tog = {4{cnt_inc[1]}}; // R5
				end
			end
			ST_DONE: begin
				s_nxt.cnt = '0;
			end
			default: begin
				s_nxt.state = ST_OFF;
			end
		endcase
		// Supply drop overrides everything and restarts from idle
		if (s_r.low_s && (s_r.state != ST_OFF)) begin
			s_nxt.state = ST_OFF; // R14 R15
			s_nxt.cnt = '0;
			s_nxt.rst_en_n = 1'b1;
			s_nxt.tog = 4'hF;
			s_nxt.flag = 1'b0; // R10
			s_nxt.i2c_sel = 1'b0;
			s_nxt.dflt_load = 1'b0;
			s_nxt.active = 1'b0; // R14
			s_nxt.sat_clk = 1'b1;
		end
		s_nxt.irq_n = ~s_nxt.flag; // R9 R11
		if (reg_rd_i) begin
			s_nxt.rdata = '0;
			if (is_flags_addr(reg_addr_i)) begin
				s_nxt.rdata[`CHPSEQ_DONE_FLAG_BIT] = s_r.flag;
			end
		end
	end

	// State register
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_r <= '{state: ST_OFF, cnt: '0, pu_m: 1'b0, pu_s: 1'b0,
				low_m: 1'b0, low_s: 1'b0, sat_clk: 1'b1,
				rst_en_n: 1'b1, tog: 4'hF, flag: 1'b0, irq_n: 1'b1,
				i2c_sel: 1'b0, dflt_load: 1'b0, active: 1'b0,
				rdata: `CHPSEQ_STATUS2_RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs
	assign reg_rdata_o = s_r.rdata;
	assign satellite_clock_output_o = s_r.sat_clk;
	assign satellite_reset_en_n_o = s_r.rst_en_n;
	assign channel_a_toggle_o = s_r.tog[0];
	assign channel_b_toggle_o = s_r.tog[1];
	assign channel_c_toggle_o = s_r.tog[2];
	assign neutral_toggle_o = s_r.tog[3];
	assign interrupt_line_one_n_o = s_r.irq_n;
	assign i2c_port_sel_o = s_r.i2c_sel;
	assign defaults_load_o = s_r.dflt_load;
	assign chip_active_o = s_r.active;

	// Falls of the toggles counted per low reset enable period
	// The first fall comes with the reset enable fall, so count by next
	logic [4:0] ast_falls;
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ast_falls <= 5'h00;
		end else if (s_nxt.rst_en_n) begin
			ast_falls <= 5'h00;
		end else if (s_r.tog[0] && !s_nxt.tog[0]) begin
			ast_falls <= ast_falls + 5'h01;
		end
	end

	// One toggle pulse: low two cycles then high
	sequence seq_tog_pulse;
		!s_r.tog[0] ##1 !s_r.tog[0] ##1 s_r.tog[0];
	endsequence

	// One satellite clock low half then rise
	sequence seq_clk_low;
		!s_r.sat_clk ##1 !s_r.sat_clk ##1 s_r.sat_clk;
	endsequence

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	AST_IDLE_QUIET: assert property ( // R1
		(s_r.state == ST_OFF) |-> (s_r.rst_en_n && s_r.sat_clk &&
			(s_r.tog == 4'hF) && !s_r.active))
		else $error("idle state drives satellite lines");
	AST_TIMEOUT_HOLD: assert property ( // R2
		(s_r.state == ST_WAIT && s_r.cnt != TIMEOUT_LAST && !s_r.low_s)
			|=> (s_r.state == ST_WAIT) && s_r.sat_clk)
		else $error("timeout left early");
	AST_SATCLK_RATE: assert property ( // R3
		($fell(s_r.sat_clk) && s_r.state == ST_DONE && !s_r.low_s &&
			!s_r.low_m) |-> seq_clk_low)
		else $error("satellite clock not quarter rate");
	AST_RST_DELAY: assert property ( // R4
		$fell(s_r.rst_en_n) |-> ($past(s_r.state) == ST_CLKRUN) &&
			($past(s_r.cnt) == RSTDLY_LAST))
		else $error("reset enable fell at wrong time");
	AST_TOG_SHAPE: assert property ( // R5
		($fell(s_r.tog[0]) && s_r.state == ST_TRAIN && !s_r.low_s &&
			!s_r.low_m) |-> seq_tog_pulse)
		else $error("toggle pulse shape wrong");
	AST_EIGHT_FALLS: assert property ( // R5
		$rose(s_r.rst_en_n) && $past(s_r.state) == ST_TRAIN &&
			s_r.state == ST_DONE |-> ($past(ast_falls) == 5'h08))
		else $error("toggle count not eight");
	AST_TOG_HIGH: assert property ( // R6
		s_r.rst_en_n |-> (s_r.tog == 4'hF))
		else $error("toggle low outside reset");
	AST_FLAG_SET: assert property ( // R9
		$rose(s_r.flag) |-> ($past(s_r.state) == ST_TRAIN) &&
			!s_r.irq_n && s_r.rst_en_n)
		else $error("done flag set out of sequence");
	AST_FLAG_ZERO: assert property ( // R10
		(s_r.state != ST_DONE) |-> !s_r.flag)
		else $error("done flag set during sequence");
	AST_FLAG_HOLD: assert property ( // R11
		(s_r.flag && !clr_wr && !s_r.low_s) |=> s_r.flag && !s_r.irq_n)
		else $error("done flag lost without clear");
	AST_PORT_DFLT: assert property ( // R12
		$rose(s_r.state == ST_DONE) |-> s_r.i2c_sel && s_r.dflt_load
			##1 !s_r.dflt_load)
		else $error("completion effects missing");
	AST_SUPPLY_DROP: assert property ( // R14
		(s_r.low_s && s_r.state != ST_OFF) |=> (s_r.state == ST_OFF) &&
			!s_r.active && !s_r.flag)
		else $error("supply drop not handled");
endmodule

//--- tb/chpseq_sat_model.sv
// Satellite front-end model: watches clock and reset pulse train
`timescale 1ns/1ps
module chpseq_sat_model (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	// Satellite link
	input  wire logic       sat_clk_i,
	input  wire logic       rst_en_n_i,
	input  wire logic [3:0] tog_i,
	// Status
	output int              falls_o,
	output logic            skew_o,
	output logic            dflt_o
);
	logic [3:0] tog_q;
	logic       en_q;

	// Count falls while held in reset; defaults once released
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tog_q <= 4'hF;
			en_q <= 1'b1;
			falls_o <= 0;
			skew_o <= 1'b0;
			dflt_o <= 1'b0;
		end else begin
			tog_q <= tog_i;
			en_q <= rst_en_n_i;
			if (en_q && !rst_en_n_i)
				dflt_o <= 1'b0;
			// A new reset restarts the count, its first fall included
			if (!rst_en_n_i && tog_q[0] && !tog_i[0])
				falls_o <= (en_q ? 0 : falls_o) + 1;
			else if (en_q && !rst_en_n_i)
				falls_o <= 0;
			if (tog_i != {4{tog_i[0]}})
				skew_o <= 1'b1;
			if (!en_q && rst_en_n_i && sat_clk_i !== 1'bx)
				dflt_o <= 1'b1;
		end
	end
endmodule

//--- tb/testbench.sv
// Self-checking bench of the power-up sequencer
`timescale 1ns/1ps
module testbench;
	import chpseq_pkg::*;
	logic        mclk_i = 0, nrst_i = 0, ok_i = 0, low_i = 0;
	logic        wr_i = 0, rd_i = 0;
	logic [15:0] addr_i = 16'h0000;
	logic [31:0] wd_i = 32'h0, rdata;
	logic        sclk, ren_n, ta, tb, tc, tn, irq_n, i2c, dld, act;
	logic        skew, dflt;
	int          falls, errors = 0, n_checks = 0, n;
	int          seed = 32'hcce6a350;
	int          exp_flag = 0;
	int          exp_q[$];

	initial forever #10 mclk_i = ~mclk_i;

	chpseq_top #(.TIMEOUT_CYC(21'd20)) dut (.mclk_i(mclk_i),
		.nrst_i(nrst_i), .supply_ok_i(ok_i), .supply_low_i(low_i),
		.reg_wr_i(wr_i), .reg_rd_i(rd_i), .reg_addr_i(addr_i),
		.reg_wdata_i(wd_i), .reg_rdata_o(rdata),
		.satellite_clock_output_o(sclk), .satellite_reset_en_n_o(ren_n),
		.channel_a_toggle_o(ta), .channel_b_toggle_o(tb),
		.channel_c_toggle_o(tc), .neutral_toggle_o(tn),
		.interrupt_line_one_n_o(irq_n), .i2c_port_sel_o(i2c),
		.defaults_load_o(dld), .chip_active_o(act));

	chpseq_sat_model sat (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.sat_clk_i(sclk), .rst_en_n_i(ren_n), .tog_i({tn, tc, tb, ta}),
		.falls_o(falls), .skew_o(skew), .dflt_o(dflt));

	// Compare one value
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic wr(logic [15:0] a, logic [31:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wd_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		if (a == 16'hE503 && d[15])
			exp_flag = 0;
	endtask

	// Read and compare with the model's next expected value
	task automatic rd(logic [15:0] a);
		exp_q.push_back((a == 16'hE503) ? exp_flag << 15 : 0);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk("rdata", exp_q.pop_front(), rdata);
	endtask

	// Full power-up from the threshold crossing
	task automatic pwrup();
		@(posedge mclk_i);
		ok_i <= 1'b1;
		n = 0;
		while (act !== 1'b1 && n < 3000) begin
			@(posedge mclk_i);
			#1 n++;
		end
		chk("pwrup_len", 1, n inside {[1050:1060]});
		chk("falls", 8, falls);
		chk("skew", 0, skew);
		chk("toggles_hi", 5'h1F, {ren_n, ta, tb, tc, tn});
		chk("irq_low", 0, irq_n);
		chk("i2c_sel", 1, i2c);
		chk("dflt_pulse", 1, dld);
		exp_flag = 1;
		// Satellites see the release one edge later
		repeat (2) @(posedge mclk_i);
		#1 chk("sat_dflt", 1, dflt);
		chk("dflt_once", 0, dld);
	endtask

	// Supply drop from a running state, then idle without supply
	task automatic drop();
		@(posedge mclk_i);
		low_i <= 1'b1;
		ok_i <= 1'b0;
		exp_flag = 0;
		repeat (4) @(posedge mclk_i);
		#1 chk("drop", 3'b001, {act, i2c, irq_n});
		rd(16'hE503);
		@(posedge mclk_i);
		low_i <= 1'b0;
		repeat (50) @(posedge mclk_i);
		#1 chk("wait_ok", 0, act);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Quarter-rate satellite clock: count rises over 40 cycles
	task automatic clk_rate();
		logic p;
		n = 0;
		p = sclk;
		repeat (40) begin
			@(posedge mclk_i);
			#1 n += (sclk && !p) ? 1 : 0;
			p = sclk;
		end
		chk("sclk_rises", 10, n);
	endtask

	initial begin
		#400000;
		errors++;
		stop_test();
	end

	initial begin
		repeat (12) @(posedge mclk_i);
		nrst_i <= 1'b1;
		repeat (100) @(posedge mclk_i);
		#1 chk("idle", 3'b011, {act, sclk, ren_n});
		rd(16'hE503);
		$display("test idle done");
		pwrup();
		clk_rate();
		rd(16'hE503);
		drop();
		pwrup();
		wr(16'hE503, $random(seed) & 32'hFFFF7FFF);
		#1 chk("irq_kept", 0, irq_n);
		wr(16'hE503, $random(seed) | 32'h00008000);
		#1 chk("irq_clr", 1, irq_n);
		rd(16'hE503);
		wr(16'h1234, $random(seed));
		rd(16'h1234);
		$display("test powerup done");
		drop();
		pwrup();
		rd(16'hE503);
		$display("test drop done");
		stop_test();
	end
endmodule
